/* core/qual_if.sv */
`timescale 1ns/1ps
`include "relay_threshold_map.svh"

interface qual_if;
	logic on_cond;
	logic off_cond;
	logic relay_state;
	logic unit_tick;
	logic [`DELAY_W-1:0] on_delay;
	logic [`DELAY_W-1:0] release_delay;
	logic fire_on;
	logic fire_off;

	modport ctrl
	(
		output on_cond,
		output off_cond,
		output relay_state,
		output unit_tick,
		output on_delay,
		output release_delay,
		input fire_on,
		input fire_off
	);

	modport qual
	(
		input on_cond,
		input off_cond,
		input relay_state,
		input unit_tick,
		input on_delay,
		input release_delay,
		output fire_on,
		output fire_off
	);
endinterface : qual_if

/* core/relay_delay_qualifier.sv */
`timescale 1ns/1ps
`include "relay_threshold_map.svh"

module relay_delay_qualifier
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// conditions in, decisions out
	qual_if.qual q
);
	logic [`DELAY_W-1:0] cnt_q;
	logic want;
	logic [`DELAY_W-1:0] limit;
	logic state_q;

	// only the transition away from the present state is timed
	assign want = q.relay_state ? q.off_cond : q.on_cond;
	assign limit = q.relay_state ? q.release_delay : q.on_delay;

	// a count left over from the opposite transition must not carry across a flip
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= 1'b0;
		else
			state_q <= q.relay_state;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= '0;
		else if (!want || q.relay_state != state_q)
			cnt_q <= '0;
		else if (q.unit_tick && cnt_q != limit)
			cnt_q <= cnt_q + 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q.fire_on <= 1'b0;
			q.fire_off <= 1'b0;
		end
		else
		begin
			q.fire_on <= want && !q.relay_state && q.relay_state == state_q && cnt_q >= limit;
			q.fire_off <= want && q.relay_state && q.relay_state == state_q && cnt_q >= limit;
		end
	end
endmodule : relay_delay_qualifier

/* core/relay_threshold_controller.sv */
`timescale 1ns/1ps
`include "relay_threshold_map.svh"

// How it works
// - disabled mode keeps relay off unless fault action forces it on.
// - energise-above mode: on above first+band, off below first-band.
// - release-above mode: off above first+band, on below first-band.
// - window mode: on between smaller+band and larger-band, off below smaller-band or above larger+band.
// - outside-window mode: on above larger+band or below smaller-band.
// - remote mode follows link commands only; host must send them.
// - LED lit exactly when relay is closed.
// - remotely commanded state is lost on reset or power loss.
// - switch on only after on-condition held for on delay.
// - switch off only after off-condition held for release delay.
// - condition lapsing before delay ends leaves relay unchanged.
// - delays counted in tenths of seconds or tenths of minutes.
// - fault action holds, forces on or forces off relay.
// - threshold modes: input out of range is the fault.
// - remote mode: link silence beyond timeout is the fault.
// - force-on fault energises relay even in disabled mode.
// - thresholds accepted from -999 to 9999, clamped outside that.
// - half band 0 to 999 applied on both sides of a threshold.
module relay_threshold_controller #(
	parameter logic [`TICK_CNT_W-1:0] TENTH_CYCLES = `TICK_CNT_W'(`TENTH_SEC_CYCLES)
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// measurement
	input wire logic signed [`VALUE_W-1:0] meas_value,
	input wire logic meas_out_of_range,
	// settings
	input wire relay_threshold_pkg::relay_mode_t relay_mode,
	input wire logic signed [`VALUE_W-1:0] first_threshold,
	input wire logic signed [`VALUE_W-1:0] second_threshold,
	input wire logic [`HALF_BAND_WIDTH_W-1:0] half_band_width,
	input wire logic [`DELAY_W-1:0] on_delay,
	input wire logic [`DELAY_W-1:0] release_delay,
	input wire logic unit_minutes,
	input wire relay_threshold_pkg::fault_action_t fault_action,
	input wire logic [`SILENCE_W-1:0] link_silence_timeout,
	// remote link
	input wire logic link_rx_activity,
	input wire logic remote_cmd_valid,
	input wire logic remote_cmd_on,
	// outputs
	output logic relay_on,
	output logic led_on,
	output logic fault_active
);
	qual_if qi();

	logic tenth_tick;
	logic unit_tick;
	logic signed [`VALUE_W-1:0] t1;
	logic signed [`VALUE_W-1:0] t2;
	logic signed [`VALUE_W-1:0] lo_t;
	logic signed [`VALUE_W-1:0] hi_t;
	logic [`HALF_BAND_WIDTH_W-1:0] band;
	logic signed [`BORDER_W-1:0] v;
	logic on_cond;
	logic off_cond;
	logic remote_q;
	logic [`SILENCE_W-1:0] silence_q;
	logic fault_d;
	logic relay_d;

	function automatic logic signed [`VALUE_W-1:0] clamp_thresh(input logic signed [`VALUE_W-1:0] t);
		if (t < `THRESH_MIN)
			return `THRESH_MIN;
		else if (t > `THRESH_MAX)
			return `THRESH_MAX;
		return t;
	endfunction : clamp_thresh

	function automatic logic signed [`BORDER_W-1:0] border(
		input logic signed [`VALUE_W-1:0] t,
		input logic [`HALF_BAND_WIDTH_W-1:0] h,
		input logic up
	);
		logic signed [`BORDER_W-1:0] ts;
		logic signed [`BORDER_W-1:0] hs;
		ts = `BORDER_W'(t);
		hs = $signed({{(`BORDER_W - `HALF_BAND_WIDTH_W){1'b0}}, h});
		return up ? ts + hs : ts - hs;
	endfunction : border

	assign t1 = clamp_thresh(first_threshold);
	assign t2 = clamp_thresh(second_threshold);
	assign lo_t = (t1 < t2) ? t1 : t2;
	assign hi_t = (t1 < t2) ? t2 : t1;
	assign band = (half_band_width > `HALF_BAND_WIDTH_MAX) ? `HALF_BAND_WIDTH_MAX : half_band_width;
	assign v = `BORDER_W'(meas_value);

	// switching borders per mode; the gap between them is the hold band
	always_comb
	begin
		on_cond = 1'b0;
		off_cond = 1'b0;
		unique case (relay_mode)
			relay_threshold_pkg::mode_energise_above:
			begin
				on_cond = v > border(t1, band, 1'b1);
				off_cond = v < border(t1, band, 1'b0);
			end
			relay_threshold_pkg::mode_release_above:
			begin
				on_cond = v < border(t1, band, 1'b0);
				off_cond = v > border(t1, band, 1'b1);
			end
			relay_threshold_pkg::mode_window:
			begin
				on_cond = v > border(lo_t, band, 1'b1) && v < border(hi_t, band, 1'b0);
				off_cond = v < border(lo_t, band, 1'b0) || v > border(hi_t, band, 1'b1);
			end
			relay_threshold_pkg::mode_outside_window:
			begin
				on_cond = v > border(hi_t, band, 1'b1) || v < border(lo_t, band, 1'b0);
				off_cond = v > border(lo_t, band, 1'b1) && v < border(hi_t, band, 1'b0);
			end
			default:
			begin
				on_cond = 1'b0;
				off_cond = 1'b0;
			end
		endcase
	end

	assign qi.on_cond = on_cond;
	assign qi.off_cond = off_cond;
	assign qi.relay_state = relay_on;
	assign qi.unit_tick = unit_tick;
	assign qi.on_delay = (on_delay > `DELAY_MAX) ? `DELAY_MAX : on_delay;
	assign qi.release_delay = (release_delay > `DELAY_MAX) ? `DELAY_MAX : release_delay;

	relay_timebase #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_timebase (
		.clk(clk),
		.arst_n(arst_n),
		.unit_minutes(unit_minutes),
		.tenth_tick(tenth_tick),
		.unit_tick(unit_tick)
	);

	relay_delay_qualifier u_qual (
		.clk(clk),
		.arst_n(arst_n),
		.q(qi)
	);

	// volatile: no storage survives reset, relay restarts released
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			remote_q <= `REMOTE_RESET;
		else if (remote_cmd_valid)
			remote_q <= remote_cmd_on;
	end

	// silence measured in tenths of a second, saturating
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			silence_q <= '0;
		else if (link_rx_activity || remote_cmd_valid)
			silence_q <= '0;
		else if (tenth_tick && silence_q != '1)
			silence_q <= silence_q + 1'b1;
	end

	always_comb
	begin
		if (relay_mode == relay_threshold_pkg::mode_remote)
			fault_d = silence_q > link_silence_timeout;
		else
			fault_d = meas_out_of_range;
	end

	always_comb
	begin
		relay_d = relay_on;
		if (fault_d)
		begin
			unique case (fault_action)
				relay_threshold_pkg::fault_force_on: relay_d = 1'b1;
				relay_threshold_pkg::fault_force_off: relay_d = 1'b0;
				default: relay_d = relay_on;
			endcase
		end
		else
		begin
			unique case (relay_mode)
				relay_threshold_pkg::mode_remote: relay_d = remote_q;
				relay_threshold_pkg::mode_energise_above,
				relay_threshold_pkg::mode_release_above,
				relay_threshold_pkg::mode_window,
				relay_threshold_pkg::mode_outside_window:
				begin
					if (qi.fire_on)
						relay_d = 1'b1;
					else if (qi.fire_off)
						relay_d = 1'b0;
				end
				default: relay_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			relay_on <= `RELAY_RESET;
			led_on <= `RELAY_RESET;
			fault_active <= 1'b0;
		end
		else
		begin
			relay_on <= relay_d;
			led_on <= relay_d;
			fault_active <= fault_d;
		end
	end
endmodule : relay_threshold_controller

/* core/relay_threshold_map.svh */
`ifndef RELAY_THRESHOLD_MAP_SVH
`define RELAY_THRESHOLD_MAP_SVH

// clock and time base
`define CLK_PERIOD_NS 10
`define TENTH_SEC_NS 100000000
`define TENTH_SEC_CYCLES (`TENTH_SEC_NS / `CLK_PERIOD_NS)
`define SEC_PER_MIN 60

// value widths
`define VALUE_W 16
`define BORDER_W 18
`define HALF_BAND_WIDTH_W 10
`define DELAY_W 10
`define SILENCE_W 16
`define TICK_CNT_W 24
`define MIN_CNT_W 6

// settings limits
`define THRESH_MIN (-16'sd999)
`define THRESH_MAX 16'sd9999
`define HALF_BAND_WIDTH_MAX 10'h3E7
`define DELAY_MAX 10'h3E7

// reset values
`define RELAY_RESET 1'b0
`define REMOTE_RESET 1'b0

`endif

/* core/relay_threshold_pkg.sv */
package relay_threshold_pkg;

	// one-hot so an undriven or corrupted code is caught by the default arm
	typedef enum logic [5:0]
	{
		relay_disabled_setting = 6'h01,
		mode_energise_above = 6'h02,
		mode_release_above = 6'h04,
		mode_window = 6'h08,
		mode_outside_window = 6'h10,
		mode_remote = 6'h20
	} relay_mode_t;

	typedef enum logic [1:0]
	{
		hold_current_state = 2'h0,
		fault_force_on = 2'h1,
		fault_force_off = 2'h2
	} fault_action_t;

endpackage : relay_threshold_pkg

/* core/relay_timebase.sv */
`timescale 1ns/1ps
`include "relay_threshold_map.svh"

module relay_timebase #(
	parameter logic [`TICK_CNT_W-1:0] TENTH_CYCLES = `TICK_CNT_W'(`TENTH_SEC_CYCLES)
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// unit select
	input wire logic unit_minutes,
	// ticks
	output logic tenth_tick,
	output logic unit_tick
);
	logic [`TICK_CNT_W-1:0] cyc_q;
	logic [`MIN_CNT_W-1:0] min_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cyc_q <= '0;
			tenth_tick <= 1'b0;
		end
		else
		begin
			tenth_tick <= (cyc_q == TENTH_CYCLES - 1'b1);
			cyc_q <= (cyc_q == TENTH_CYCLES - 1'b1) ? '0 : cyc_q + 1'b1;
		end
	end

	// a tenth of a minute is sixty tenths of a second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			min_q <= '0;
			unit_tick <= 1'b0;
		end
		else
		begin
			if (tenth_tick)
				min_q <= (min_q == `MIN_CNT_W'(`SEC_PER_MIN - 1)) ? '0 : min_q + 1'b1;
			unit_tick <= unit_minutes ? (tenth_tick && min_q == `MIN_CNT_W'(`SEC_PER_MIN - 1)) : tenth_tick;
		end
	end
endmodule : relay_timebase

/* verif/relay_far_side_model.sv */
`timescale 1ns/1ps
module relay_far_side_model
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bench requests
	input wire logic send,
	input wire logic send_on,
	input wire logic [15:0] want_value,
	input wire logic want_oor,
	// toward the controller
	output logic [15:0] meas_value,
	output logic meas_out_of_range,
	output logic remote_cmd_valid,
	output logic remote_cmd_on,
	output logic link_rx_activity
);
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			meas_value <= 16'h0000;
			meas_out_of_range <= 1'b0;
			remote_cmd_valid <= 1'b0;
			remote_cmd_on <= 1'b0;
			link_rx_activity <= 1'b0;
		end
		else
		begin
			meas_value <= want_value;
			meas_out_of_range <= want_oor;
			remote_cmd_valid <= send;
			// command bit is meaningless outside valid, so it never sits still there
			remote_cmd_on <= send ? send_on : ~remote_cmd_on;
			link_rx_activity <= send;
		end
endmodule : relay_far_side_model

/* verif/relay_threshold_assertions.sv */
`timescale 1ns/1ps
module relay_threshold_assertions
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// watched ports
	input wire logic meas_out_of_range,
	input wire relay_threshold_pkg::relay_mode_t relay_mode,
	input wire relay_threshold_pkg::fault_action_t fault_action,
	input wire logic remote_cmd_valid,
	input wire logic remote_cmd_on,
	input wire logic relay_on,
	input wire logic led_on,
	input wire logic fault_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic oor;
	logic ok;
	assign oor = meas_out_of_range && relay_mode != 6'h20;
	// remote mode with no silence fault that could mask a command
	assign ok = relay_mode == 6'h20 && !fault_active;
	a_led_tracks_relay: assert property (led_on == relay_on) else $error("led mismatch");
	a_disabled_stays_off: assert property ((relay_mode == 6'h01 && !meas_out_of_range)[*6] |-> !relay_on)
		else $error("relay on while disabled");
	a_range_fault: assert property (oor |=> fault_active) else $error("no range fault");
	a_force_on_wins: assert property (oor && fault_action == 2'h1 |=> relay_on) else $error("no force on");
	a_force_off_wins: assert property (oor && fault_action == 2'h2 |=> !relay_on) else $error("no force off");
	a_hold_keeps_state: assert property ((oor && fault_action == 2'h0)[*3] |=> $stable(relay_on))
		else $error("relay moved on hold");
	a_remote_follows_cmd: assert property ((ok && remote_cmd_valid) ##1 (ok && !remote_cmd_valid) ##1 ok
		|-> relay_on == $past(remote_cmd_on, 2)) else $error("command missed");
	a_remote_ignores_meas: assert property ((ok && !remote_cmd_valid)[*4] ##1 ok |-> $stable(relay_on))
		else $error("relay moved without command");
	cover property (oor && fault_action == 2'h1 ##1 relay_on);
	cover property (ok && remote_cmd_valid);
	cover property (relay_mode == 6'h01 ##1 relay_on);
endmodule : relay_threshold_assertions

bind relay_threshold_controller relay_threshold_assertions i_relay_threshold_assertions (.clk, .arst_n,
	.meas_out_of_range, .relay_mode, .fault_action, .remote_cmd_valid, .remote_cmd_on, .relay_on, .led_on,
	.fault_active);

/* verif/relay_threshold_controller_tb.sv */
`timescale 1ns/1ps
module relay_threshold_controller_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic send = 1'b0;
	logic send_on = 1'b0;
	logic want_oor = 1'b0;
	logic minutes = 1'b0;
	logic exp_on = 1'b0;
	logic [15:0] want_value = 16'h0000;
	logic [15:0] silence = 16'h0005;
	logic [5:0] mode = 6'h01;
	logic [1:0] fault = 2'h0;
	logic signed [15:0] t1 = 16'h0000;
	logic signed [15:0] t2 = 16'h0000;
	logic [9:0] band = 10'h000;
	logic [9:0] dly_on = 10'h000;
	logic [9:0] dly_off = 10'h000;
	logic [15:0] meas_value;
	logic meas_out_of_range, remote_cmd_valid, remote_cmd_on, link_rx_activity, relay_on, led_on, fault_active;
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	relay_far_side_model i_relay_far_side_model (.clk, .arst_n, .send, .send_on, .want_value, .want_oor,
		.meas_value, .meas_out_of_range, .remote_cmd_valid, .remote_cmd_on, .link_rx_activity);

	// tenth ticks shortened to 10 clocks
	relay_threshold_controller #(.TENTH_CYCLES(24'h00000A)) i_relay_threshold_controller (.clk, .arst_n,
		.meas_value, .meas_out_of_range, .relay_mode(relay_threshold_pkg::relay_mode_t'(mode)),
		.first_threshold(t1), .second_threshold(t2), .half_band_width(band), .on_delay(dly_on),
		.release_delay(dly_off), .unit_minutes(minutes), .fault_action(relay_threshold_pkg::fault_action_t'(fault)),
		.link_silence_timeout(silence), .link_rx_activity, .remote_cmd_valid, .remote_cmd_on, .relay_on, .led_on,
		.fault_active);

	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// a change must not show before the lower bound of its delay, and must show after the upper
	task automatic delayed(input logic [15:0] val, input int early, input int late, input logic to);
		want_value = val;
		step(early);
		check("before delay", relay_on, !to);
		step(late);
		check("after delay", relay_on, to);
	endtask : delayed

	// band interior keeps the previous state
	function automatic logic model(input int m, input int v, input logic prev);
		int a;
		int b;
		int h;
		a = t1 < t2 ? t1 : t2;
		b = t1 < t2 ? t2 : t1;
		h = band;
		case (m)
			0: return v > t1 + h ? 1'b1 : v < t1 - h ? 1'b0 : prev;
			1: return v > t1 + h ? 1'b0 : v < t1 - h ? 1'b1 : prev;
			2: return v > a + h && v < b - h ? 1'b1 : v < a - h || v > b + h ? 1'b0 : prev;
			default: return v > b + h || v < a - h ? 1'b1 : v > a + h && v < b - h ? 1'b0 : prev;
		endcase
	endfunction : model

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			error_cnt++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(32'h8F193013));
		step(5);
		arst_n = 1'b1;
		step(1);
		for (int m = 0; m < 4; m++)
		begin
			mode = 6'h02 << m;
			t1 = 16'($urandom_range(400)) - 16'h00C8;
			t2 = 16'($urandom_range(400)) - 16'h00C8;
			for (int i = 0; i < 40; i++)
			begin
				band = 10'($urandom_range(30));
				// the old value meets the new settings for one cycle before the new value arrives
				exp_on = model(m, $signed(want_value), exp_on);
				want_value = i % 4 ? 16'($urandom_range(1200)) - 16'h0258 : t1 + 16'(band);
				step(6);
				exp_on = model(m, $signed(want_value), exp_on);
				check("relay", relay_on, exp_on);
				check("led", led_on, exp_on);
			end
		end
		mode = 6'h02;
		t1 = 16'h0000;
		band = 10'h000;
		want_value = 16'hFFFB;
		step(6);
		dly_on = 10'h003;
		dly_off = 10'h003;
		want_value = 16'h0005;
		step(15);
		want_value = 16'hFFFB;
		step(40);
		check("lapse", relay_on, 1'b0);
		delayed(16'h0005, 18, 20, 1'b1);
		delayed(16'hFFFB, 18, 20, 1'b0);
		dly_on = 10'h002;
		minutes = 1'b1;
		delayed(16'h0005, 500, 750, 1'b1);
		minutes = 1'b0;
		for (int f = 0; f < 3; f++)
		begin
			fault = 2'(f);
			want_oor = 1'b1;
			want_value = 16'hFFFB;
			step(4);
			check("fault flag", fault_active, 1'b1);
			check("fault relay", relay_on, f != 2);
			want_oor = 1'b0;
			want_value = 16'h0005;
			step(40);
		end
		mode = 6'h01;
		fault = 2'h1;
		step(8);
		check("disabled", relay_on, 1'b0);
		want_oor = 1'b1;
		step(3);
		check("disabled forced", relay_on, 1'b1);
		want_oor = 1'b0;
		step(3);
		mode = 6'h20;
		fault = 2'h2;
		for (int i = 0; i < 6; i++)
		begin
			exp_on = 1'($urandom_range(1));
			send = 1'b1;
			send_on = ~exp_on;
			step(1);
			send_on = exp_on;
			step(1);
			send = 1'b0;
			want_value = 16'($urandom);
			step(4);
			check("remote", relay_on, exp_on);
		end
		step(40);
		check("quiet link", fault_active, 1'b0);
		step(35);
		check("silent link", fault_active, 1'b1);
		check("silent relay", relay_on, 1'b0);
		fault = 2'h0;
		send = 1'b1;
		send_on = 1'b1;
		step(1);
		send = 1'b0;
		step(4);
		check("before reset", relay_on, 1'b1);
		arst_n = 1'b0;
		step(2);
		arst_n = 1'b1;
		step(3);
		check("after reset", relay_on, 1'b0);
		conclude();
	end
endmodule : relay_threshold_controller_tb
